/* rtl/sleep_wake_pkg.sv */
// constants for the sleep and wake controller
// assumes a single 125 MHz system clock
package sleep_wake_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // oscillator periods of start-up delay
    localparam int unsigned OSC_STARTUP_PERIODS = 1024;
    // one oscillator period is one system clock here
    localparam int unsigned OSC_STARTUP_CYCLES = OSC_STARTUP_PERIODS;
    localparam int unsigned OST_W = 11;
    localparam logic [13:0] INT_VECTOR = 14'h0004;
    localparam int unsigned NUM_SRC = 6;
    // source index within the wake vector
    localparam int unsigned SRC_TMR1 = 0;
    localparam int unsigned SRC_CAPTURE = 1;
    localparam int unsigned SRC_ADC = 2;
    localparam int unsigned SRC_CMP = 3;
    localparam int unsigned SRC_IOC = 4;
    localparam int unsigned SRC_INT_PIN = 5;
    localparam logic PD_RESET = 1'b1;
    localparam logic TO_RESET = 1'b1;
    // oscillator mode encodings
    localparam logic [2:0] OSC_LP = 3'h0;
    localparam logic [2:0] OSC_XT = 3'h1;
    localparam logic [2:0] OSC_HS = 3'h2;
    localparam logic [2:0] OSC_EC = 3'h3;
    localparam logic [2:0] OSC_INT = 3'h4;
    localparam logic [2:0] OSC_RC = 3'h5;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STARTUP, ST_RESUME} state_t;
endpackage

/* rtl/wake_source_gate.sv */
// gates peripheral interrupt flags into one wake request
// assumes flags and enables come from the system clock domain
`timescale 1ns/1ps
module wake_source_gate
    import sleep_wake_pkg::*;
(
    // source flags and enables
    input wire logic [NUM_SRC-1:0] int_flag,
    input wire logic [NUM_SRC-1:0] int_enable,
    // timer1 counting asynchronously
    input wire logic tmr1_async,
    // adc clocked from its rc clock
    input wire logic adc_rc_clock,
    // gated result
    output logic wake_req
);
    logic [NUM_SRC-1:0] qual;
    always_comb begin
        qual = int_flag & int_enable; // RL12
        // clocked peripherals cannot wake
        qual[SRC_TMR1] = qual[SRC_TMR1] & tmr1_async; // RL9 RL10
        qual[SRC_ADC] = qual[SRC_ADC] & adc_rc_clock; // RL9 RL10
        wake_req = |qual; // RL22
    end
endmodule

/* rtl/sleep_wake_control.sv */
// sleep entry, wake-up and status flags for a small 8-bit core
// assumes the core pulses sleep_instr and watchdog_clear_instr for one clock,
// and that the watchdog counter obeys wdt_clear
// Operation
// RL1: sleep clears watchdog, watchdog keeps running
// RL2: sleep clears power-down flag, sets time-out
// RL3: oscillator driver off during sleep
// RL4: io drive state held during sleep
// RL5: watchdog reset internal, never drives reset pin
// RL6: wake on pin reset, watchdog, interrupt
// RL7: pin reset resets; others continue
// RL8: watchdog wake clears time-out flag
// RL9: only six peripheral sources can wake
// RL10: clocked peripherals cannot interrupt in sleep
// RL11: next instruction prefetched during sleep
// RL12: individual enable needed, global enable ignored
// RL13: global enable picks inline or vector 0004h
// RL14: pending flag before sleep makes it nop; the code does so only with global enable clear
// RL15: flag during sleep wakes, sleep counts
// RL16: every wake clears watchdog count
// RL17: software checks power-down flag, clears watchdog
// RL18: software puts nop after sleep
// RL19: crystal modes wait 1024 periods on wake
// RL20: clear instr and sleep clear watchdog
// RL21: watchdog resets when awake, wakes when asleep
// RL22: wake detection combinational on flags
`timescale 1ns/1ps
module sleep_wake_control
    import sleep_wake_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // core requests
    input wire logic sleep_instr,
    input wire logic watchdog_clear_instr,
    input wire logic global_int_enable,
    input wire logic [2:0] osc_mode,
    // watchdog
    input wire logic wdt_enable,
    input wire logic wdt_timeout,
    // external reset pin, active low, asynchronous
    input wire logic external_reset_pin_n,
    // interrupt sources
    input wire logic [NUM_SRC-1:0] int_flag,
    input wire logic [NUM_SRC-1:0] int_enable,
    input wire logic tmr1_async,
    input wire logic adc_rc_clock,
    // io drive state from the core
    input wire logic [5:0] io_out_in,
    input wire logic [5:0] io_oe_in,
    // io drive state to the pads
    output logic [5:0] io_out,
    output logic [5:0] io_oe,
    // watchdog control
    output logic wdt_clear,
    output logic wdt_run,
    // clocks and core control
    output logic osc_drive_en,
    output logic core_clk_en,
    output logic prefetch_next,
    output logic device_reset,
    output logic reset_pin_drive_low,
    output logic resume_pulse,
    output logic vector_take,
    output logic [13:0] vector_addr,
    // status
    output logic power_down_flag,
    output logic timeout_flag,
    output logic asleep
);
    state_t state_r;
    logic pd_r;
    logic to_r;
    logic [OST_W-1:0] ost_r;
    logic [5:0] hold_out_r;
    logic [5:0] hold_oe_r;
    logic rst_s1_r;
    logic rst_s2_r;
    logic vec_r;
    logic res_r;
    logic dev_rst_r;
    logic wake_irq;
    logic pin_reset;
    logic wdt_wake;
    logic sleep_go;
    logic sleep_nop;
    logic crystal;
    logic wake_any;

    wake_source_gate u_gate (
        .int_flag(int_flag),
        .int_enable(int_enable),
        .tmr1_async(tmr1_async),
        .adc_rc_clock(adc_rc_clock),
        .wake_req(wake_irq)
    );

    // reset pin synchroniser
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= 1'b1;
        end else begin
            rst_s1_r <= external_reset_pin_n;
            rst_s2_r <= rst_s1_r;
        end
    end

    assign pin_reset = !rst_s2_r;
    assign wdt_wake = wdt_enable && wdt_timeout;
    assign crystal = (osc_mode == OSC_LP) || (osc_mode == OSC_XT) || (osc_mode == OSC_HS);
    // pending enabled flag with global enable clear turns sleep into nop
    assign sleep_nop = sleep_instr && !global_int_enable && wake_irq; // RL14
    assign sleep_go = sleep_instr && (state_r == ST_RUN) && !sleep_nop;
    assign wake_any = pin_reset || wdt_wake || wake_irq; // RL6 RL22

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= ST_RUN;
        end else if (pin_reset) begin
            state_r <= ST_RUN; // RL7
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    if (sleep_go) begin
                        state_r <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wdt_wake || wake_irq) begin // RL6 RL15
                        state_r <= crystal ? ST_STARTUP : ST_RESUME; // RL19
                    end
                end
                ST_STARTUP: begin
                    if (ost_r == OST_W'(OSC_STARTUP_CYCLES - 1)) begin // RL19
                        state_r <= ST_RESUME;
                    end
                end
                ST_RESUME: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // start-up delay counter
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ost_r <= '0;
        end else if (state_r == ST_STARTUP) begin
            ost_r <= ost_r + OST_W'(1);
        end else begin
            ost_r <= '0;
        end
    end

    // status flags
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pd_r <= PD_RESET; // RL2
            to_r <= TO_RESET;
        end else if (sleep_go) begin
            pd_r <= 1'b0; // RL2
            to_r <= 1'b1; // RL2
        end else if (state_r == ST_SLEEP && wdt_wake && !pin_reset) begin
            to_r <= 1'b0; // RL8
        end else if (state_r == ST_RUN && watchdog_clear_instr) begin
            pd_r <= 1'b1;
            to_r <= 1'b1;
        end else if (state_r == ST_RUN && wdt_wake) begin
            to_r <= 1'b0;
        end
    end

    // io hold latched at sleep entry
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hold_out_r <= '0;
            hold_oe_r <= '0;
        end else if (sleep_go) begin
            hold_out_r <= io_out_in; // RL4
            hold_oe_r <= io_oe_in;
        end
    end

    // resume actions
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            vec_r <= 1'b0;
            res_r <= 1'b0;
            dev_rst_r <= 1'b0;
        end else begin
            res_r <= (state_r == ST_RESUME) && !pin_reset; // RL7
            vec_r <= (state_r == ST_RESUME) && !pin_reset && global_int_enable; // RL13
            // awake watchdog time-out resets, pin reset always resets
            dev_rst_r <= pin_reset || (state_r == ST_RUN && wdt_wake); // RL7 RL21
        end
    end

    assign io_out = (state_r == ST_RUN) ? io_out_in : hold_out_r; // RL4
    assign io_oe = (state_r == ST_RUN) ? io_oe_in : hold_oe_r; // RL4
    // sleep, watchdog-clear and every wake clear the count
    assign wdt_clear = sleep_go || (state_r == ST_RUN && watchdog_clear_instr)
        || (state_r == ST_SLEEP && wake_any) || (state_r == ST_STARTUP); // RL1 RL16 RL20
    assign wdt_run = wdt_enable; // RL1
    assign osc_drive_en = (state_r != ST_SLEEP); // RL3
    assign core_clk_en = (state_r == ST_RUN) || (state_r == ST_RESUME); // RL3 RL10
    assign prefetch_next = sleep_go; // RL11
    assign reset_pin_drive_low = 1'b0; // RL5
    assign device_reset = dev_rst_r;
    assign resume_pulse = res_r;
    assign vector_take = vec_r;
    assign vector_addr = INT_VECTOR; // RL13
    assign power_down_flag = pd_r;
    assign timeout_flag = to_r;
    assign asleep = (state_r == ST_SLEEP);

    sequence wake_seq;
        (state_r == ST_SLEEP) && (wdt_wake || wake_irq) && !pin_reset;
    endsequence

    // steps of a wake, split by clock source
    sequence crystal_wake_seq;
        wake_seq ##0 crystal;
    endsequence

    sequence fast_wake_seq;
        wake_seq ##0 !crystal;
    endsequence

    sequence ost_run_seq;
        (state_r == ST_STARTUP) && (ost_r != OST_W'(OSC_STARTUP_CYCLES - 1)) && !pin_reset;
    endsequence

    sequence ost_end_seq;
        (state_r == ST_STARTUP) && (ost_r == OST_W'(OSC_STARTUP_CYCLES - 1)) && !pin_reset;
    endsequence

    sequence resume_seq;
        (state_r == ST_RESUME) && !pin_reset;
    endsequence

    // requests seen while awake
    sequence nop_sleep_seq;
        (state_r == ST_RUN) && sleep_nop && !watchdog_clear_instr && !wdt_wake;
    endsequence

    sequence clear_instr_seq;
        (state_r == ST_RUN) && watchdog_clear_instr && !sleep_go && !pin_reset;
    endsequence

    sequence awake_wdt_seq;
        (state_r == ST_RUN) && wdt_wake && !watchdog_clear_instr && !sleep_go && !pin_reset;
    endsequence

    sequence entry_seq;
        sleep_go && !pin_reset;
    endsequence

    sleep_flags_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sleep_go |=> !power_down_flag && timeout_flag) // RL2
        else $error("sleep entry flags wrong");
    sleep_nop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_r == ST_RUN) && sleep_nop |=> state_r == ST_RUN && $stable(pd_r)) // RL14
        else $error("nop sleep changed state");
    osc_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        asleep |-> !osc_drive_en && !core_clk_en) // RL3
        else $error("clock runs in sleep");
    io_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sleep_go |=> io_out == $past(io_out_in) && io_oe == $past(io_oe_in)) // RL4
        else $error("io not held");
    wdt_wake_to_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_r == ST_SLEEP) && wdt_wake && !pin_reset |=> !timeout_flag) // RL8
        else $error("timeout flag not cleared");
    wake_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wake_seq |-> wdt_clear) // RL16
        else $error("watchdog not cleared on wake");
    fast_resume_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wake_seq ##0 !crystal ##1 !pin_reset |-> ##1 resume_pulse) // RL19 RL7
        else $error("no resume after wake");
    startup_wait_a: assert property (@(posedge clk_sys) disable iff (sys_rst || pin_reset)
        wake_seq ##0 crystal |=> (state_r == ST_STARTUP) [*8]) // RL19
        else $error("startup delay skipped");
    vector_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        vector_take |-> resume_pulse && $past(global_int_enable)) // RL13
        else $error("vector without global enable");
    pin_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pin_reset |=> device_reset && !resume_pulse) // RL7
        else $error("pin reset missed");
    no_pin_drive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wdt_wake |-> !reset_pin_drive_low) // RL5
        else $error("reset pin driven");

    // wake, start-up, resume, awake-request and sleep steps
    crystal_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        crystal_wake_seq |=> state_r == ST_STARTUP && ost_r == '0) // RL19
        else $error("startup not entered");
    fast_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fast_wake_seq |=> state_r == ST_RESUME && core_clk_en) // RL19 RL3
        else $error("fast wake stalled");
    ost_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ost_run_seq |=> state_r == ST_STARTUP) // RL19
        else $error("startup delay cut short");
    ost_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ost_end_seq |=> state_r == ST_RESUME) // RL19
        else $error("startup delay overran");
    ost_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == ST_STARTUP |-> wdt_clear && !core_clk_en) // RL16 RL19
        else $error("watchdog runs in startup");
    resume_once_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        resume_seq |=> resume_pulse && state_r == ST_RUN && !device_reset) // RL7
        else $error("resume step lost");
    vector_gie_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        resume_seq |=> vector_take == $past(global_int_enable)) // RL13
        else $error("vector choice wrong");
    nop_flags_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        nop_sleep_seq |=> $stable(power_down_flag) && $stable(timeout_flag)) // RL14
        else $error("nop sleep changed flags");
    nop_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        nop_sleep_seq |-> !wdt_clear && !prefetch_next) // RL14 RL11
        else $error("nop sleep cleared watchdog");
    clear_instr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clear_instr_seq |-> wdt_clear ##1 (power_down_flag && timeout_flag)) // RL20
        else $error("watchdog clear ignored");
    awake_wdt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        awake_wdt_seq |=> device_reset && !timeout_flag) // RL21
        else $error("awake time-out not reset");
    asleep_wdt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wake_seq ##0 wdt_wake |=> !device_reset && !asleep) // RL21 RL6
        else $error("sleep time-out reset core");
    sleep_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        entry_seq |=> asleep && !osc_drive_en && !core_clk_en) // RL3 RL6
        else $error("sleep not entered");
    entry_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        entry_seq |-> wdt_clear && prefetch_next) // RL1 RL11
        else $error("sleep entry missed clear");
    stay_asleep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        asleep && !wake_any |=> asleep) // RL6
        else $error("woke without cause");
    irq_wake_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        asleep && wake_irq && !pin_reset |=> !asleep) // RL12 RL15
        else $error("interrupt did not wake");
    pin_wake_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        asleep && pin_reset |=> !asleep && !resume_pulse) // RL6 RL7
        else $error("pin reset left sleep badly");
    io_steady_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        asleep && $past(asleep) |-> $stable(io_out) && $stable(io_oe)) // RL4
        else $error("io moved in sleep");
    watchdog_runs_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        asleep && wdt_enable |-> wdt_run) // RL1
        else $error("watchdog stopped in sleep");
endmodule

/* verif/watchdog_model.sv */
// watchdog counter model for the sleep and wake bench
// assumes the controller's wdt_run and wdt_clear outputs
`timescale 1ns/1ps
module watchdog_model #(
    parameter int LIMIT = 40
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // control
    input wire logic wdt_run,
    input wire logic wdt_clear,
    // expiry
    output logic wdt_timeout
);
    logic [15:0] count_r;
    // keeps counting through sleep on the system clock
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !wdt_run || wdt_clear) begin
            count_r <= 16'h0000;
        end else begin
            count_r <= count_r + 16'h0001;
        end
    end
    assign wdt_timeout = (count_r == LIMIT[15:0]);
endmodule

/* verif/test_sleep_wake_control.sv */
// self-checking bench for the sleep and wake controller
// assumes a watchdog model on the watchdog ports
`timescale 1ns/1ps
module test_sleep_wake_control;
    import sleep_wake_pkg::*;
    logic clk_sys = 1'b0, sys_rst = 1'b1, sleep_instr = 1'b0, watchdog_clear_instr = 1'b0;
    logic global_int_enable = 1'b0, wdt_enable = 1'b0, external_reset_pin_n = 1'b1;
    logic tmr1_async = 1'b1, adc_rc_clock = 1'b1, wdt_timeout, wdt_clear, wdt_run;
    logic [2:0] osc_mode = OSC_EC;
    logic [5:0] int_flag = 6'h00, int_enable = 6'h00, io_out_in = 6'h00, io_oe_in = 6'h00;
    logic [5:0] io_out, io_oe;
    logic osc_drive_en, core_clk_en, prefetch_next, device_reset, reset_pin_drive_low;
    logic resume_pulse, vector_take, power_down_flag, timeout_flag, asleep;
    logic [13:0] vector_addr;
    int err_total = 0, checks = 0, cyc = 0;
    always #4 clk_sys = ~clk_sys;
    sleep_wake_control u_sleep_wake_control (.*);
    watchdog_model u_watchdog_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .wdt_run(wdt_run),
        .wdt_clear(wdt_clear), .wdt_timeout(wdt_timeout));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic go_sleep();
        sleep_instr = 1'b1;
        #1;
        check("prefetch", prefetch_next, 1);
        check("wdt_clear", wdt_clear, 1);
        tick();
        sleep_instr = 1'b0;
        check("asleep", asleep, 1);
        check("pd", power_down_flag, 0);
        check("to", timeout_flag, 1);
        check("osc", {osc_drive_en, core_clk_en}, 0);
    endtask
    task automatic wait_resume(output int n);
        n = 0;
        while (resume_pulse !== 1'b1 && n < 1200) begin
            tick();
            n++;
        end
    endtask
    task automatic t_reset();
        check("pd", power_down_flag, 1);
        check("pin", reset_pin_drive_low, 0);
        check("vec", vector_addr, 14'h0004);
    endtask
    task automatic t_int();
        logic [2:0] m [3] = '{OSC_EC, OSC_INT, OSC_RC};
        int n;
        int_enable = 6'h3f;
        for (int s = 0; s < 6; s++) begin
            global_int_enable = s[0];
            osc_mode = m[s % 3];
            io_out_in = 6'h2a;
            io_oe_in = 6'h0f;
            go_sleep();
            io_out_in = 6'h15;
            io_oe_in = 6'h30;
            tick();
            check("io", {io_out, io_oe}, 12'ha8f);
            int_flag = 6'h01 << s;
            #1;
            check("wake clr", wdt_clear, 1);
            wait_resume(n);
            check("fast", n < 4, 1);
            check("vector", vector_take, s[0]);
            check("rst", device_reset, 0);
            int_flag = 6'h00;
            tick();
            check("awake", {asleep, core_clk_en, osc_drive_en}, 3'h3);
            check("io run", {io_out, io_oe}, 12'h570);
        end
    endtask
    task automatic t_nop();
        watchdog_clear_instr = 1'b1;
        #1;
        check("clr instr", wdt_clear, 1);
        tick();
        watchdog_clear_instr = 1'b0;
        global_int_enable = 1'b0;
        int_enable = 6'h20;
        int_flag = 6'h20;
        sleep_instr = 1'b1;
        #1;
        check("nop clr", wdt_clear, 0);
        tick();
        sleep_instr = 1'b0;
        check("nop", {asleep, power_down_flag, timeout_flag}, 3'h3);
        int_flag = 6'h00;
    endtask
    task automatic t_gate();
        int n;
        tmr1_async = 1'b0;
        adc_rc_clock = 1'b0;
        go_sleep();
        int_enable = 6'h05;
        int_flag = 6'h05;
        repeat (5) tick();
        check("gated", asleep, 1);
        int_enable = 6'h00;
        int_flag = 6'h3f;
        repeat (5) tick();
        check("masked", asleep, 1);
        int_enable = 6'h10;
        wait_resume(n);
        check("ioc", resume_pulse, 1);
        int_flag = 6'h00;
        tmr1_async = 1'b1;
        adc_rc_clock = 1'b1;
    endtask
    task automatic t_wdt();
        int n;
        wdt_enable = 1'b1;
        go_sleep();
        check("wdt run", wdt_run, 1);
        wait_resume(n);
        check("wdt wake", {resume_pulse, device_reset}, 2'h2);
        check("to wake", timeout_flag, 0);
        n = 0;
        while (device_reset !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        check("wdt rst", device_reset, 1);
        check("pin", reset_pin_drive_low, 0);
        wdt_enable = 1'b0;
        tick();
    endtask
    task automatic t_xtal();
        logic [2:0] m [3] = '{OSC_LP, OSC_XT, OSC_HS};
        int n;
        int_enable = 6'h20;
        for (int i = 0; i < 3; i++) begin
            osc_mode = m[i];
            go_sleep();
            int_flag = 6'h20;
            wait_resume(n);
            check("ost", n >= 1024 && n < 1100, 1);
            int_flag = 6'h00;
            tick();
        end
        osc_mode = OSC_EC;
    endtask
    task automatic t_pin();
        logic rs = 1'b0, rp = 1'b0;
        go_sleep();
        external_reset_pin_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            tick();
            rs |= device_reset;
            rp |= resume_pulse;
            if (i == 2) external_reset_pin_n = 1'b1;
        end
        check("pin rst", {rs, rp, asleep}, 3'h4);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_int();
        t_nop();
        t_gate();
        t_wdt();
        t_xtal();
        t_pin();
        summarize();
    end
endmodule
